//--- design/tacl_core.sv
// Purpose: Digital core of a 10-bit tracking converter: counter, latch, serial out
// Assumes: Conversion clock, comparator, strobe and send data pins are asynchronous
// Notes:   Serial data clock is a second domain; it may stand still between reads
`timescale 1ns/1ps
module tacl_core #(
    parameter int RESULT_W = tacl_pkg::RESULT_W
) (
    input  wire logic                clk,
    input  wire logic                nrst,
    input  wire logic                ce,
    input  wire logic                conv_clk_pin,
    input  wire logic                dac_below_pin,
    input  wire logic                dac_above_pin,
    input  wire logic                xfer_strobe_pin,
    input  wire logic                send_data_pin,
    input  wire logic                data_clk,
    output logic [RESULT_W-1:0]      dac_code,
    output logic [RESULT_W-1:0]      bit_out,
    output logic [RESULT_W-1:0]      bit_oe
);
    // Pin and return-path synchronisers in the system domain
    tacl_sync_if #(.W(10)) pin_if ();

    logic                  ack_link_reg;
    logic [3:0]            gray_link_reg;
    logic                  tog_reg;

    assign pin_if.raw = {gray_link_reg, ack_link_reg, send_data_pin, xfer_strobe_pin,
                         dac_above_pin, dac_below_pin, conv_clk_pin};

    tacl_sync #(.W(10)) u_pin_sync (
        .clk  (clk),
        .en   (ce),
        .port (pin_if)
    );

    wire       conv_s  = pin_if.sync[0];
    wire       below_s = pin_if.sync[1];
    wire       above_s = pin_if.sync[2];
    wire       xfer_s  = pin_if.sync[3];
    wire       send_s  = pin_if.sync[4];
    wire       ack_s   = pin_if.sync[5];
    wire [3:0] gray_s  = pin_if.sync[9:6];

    // Conversion clock and transfer strobe edges
    logic conv_prev_reg;
    logic xfer_prev_reg;
    wire  conv_rise = conv_s & ~conv_prev_reg;
    wire  conv_fall = ~conv_s & conv_prev_reg;
    wire  xfer_fall = ~xfer_s & xfer_prev_reg;

    // Comparator decision; both flags at once is treated as a hold
    tacl_pkg::tacl_dir_t dir_reg;
    tacl_pkg::tacl_dir_t dir_next;
    assign dir_next = (below_s && !above_s) ? tacl_pkg::TACL_UP :
                      (above_s && !below_s) ? tacl_pkg::TACL_DOWN :
                      tacl_pkg::TACL_HOLD;

    // Up/down counter
    logic [RESULT_W-1:0] count_reg;
    logic [RESULT_W-1:0] count_next;
    wire  at_top    = (count_reg == tacl_pkg::COUNT_TOP);
    wire  at_bottom = (count_reg == tacl_pkg::COUNT_BOTTOM);
    wire  step_up   = conv_fall && dir_reg == tacl_pkg::TACL_UP && !at_top;
    wire  step_down = conv_fall && dir_reg == tacl_pkg::TACL_DOWN && !at_bottom;
    assign count_next = step_up   ? count_reg + 10'h001 :
                        step_down ? count_reg - 10'h001 :
                        count_reg;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            conv_prev_reg <= 1'b0;
            xfer_prev_reg <= 1'b0;
            dir_reg       <= tacl_pkg::TACL_HOLD;
            count_reg     <= tacl_pkg::COUNT_RESET;
        end else if (ce) begin
            conv_prev_reg <= conv_s;
            xfer_prev_reg <= xfer_s;
            if (conv_rise) begin
                dir_reg <= dir_next;
            end
            count_reg <= count_next;
        end
    end

    assign dac_code = count_reg;

    // Output latch: follows while strobe high, holds from its falling edge
    logic [RESULT_W-1:0] held_reg;
    always_ff @(posedge clk) begin
        if (!nrst) begin
            held_reg <= tacl_pkg::COUNT_RESET;
            tog_reg  <= 1'b0;
        end else if (ce) begin
            if (xfer_s || xfer_fall) begin
                held_reg <= count_reg;
            end
            if (xfer_fall) begin
                tog_reg <= ~tog_reg;
            end
        end
    end

    // Shift position returned from the data clock domain
    logic [3:0] gray_bin;
    assign gray_bin = {gray_s[3], gray_s[3] ^ gray_s[2], gray_s[3] ^ gray_s[2] ^ gray_s[1],
                       gray_s[3] ^ gray_s[2] ^ gray_s[1] ^ gray_s[0]};

    // Ack and count may land a cycle apart, so wait one extra cycle of agreement
    logic ack_ok_reg;
    wire  ack_match = (ack_s == tog_reg);
    always_ff @(posedge clk) begin
        if (!nrst) begin
            ack_ok_reg <= 1'b0;
        end else if (ce) begin
            ack_ok_reg <= ack_match && !xfer_s;
        end
    end

    wire  [3:0]          shift_amt = (ack_ok_reg && ack_match && !xfer_s) ? gray_bin : 4'h0;
    wire  [RESULT_W-1:0] out_word  = (shift_amt >= tacl_pkg::SHIFT_LAST) ? '0 :
                                     RESULT_W'(held_reg << shift_amt);

    // Index RESULT_W-1 is bit 1, the heaviest; index 0 is bit 10
    always_ff @(posedge clk) begin
        if (!nrst) begin
            bit_out <= '0;
            bit_oe  <= '0;
        end else if (ce) begin
            bit_out <= out_word;
            bit_oe  <= {RESULT_W{send_s}};
        end
    end

    // Data clock domain: counts shifts since the last latch event
    tacl_sync_if #(.W(2)) dclk_if ();
    assign dclk_if.raw = {nrst, tog_reg};

    tacl_sync #(.W(2)) u_dclk_sync (
        .clk  (data_clk),
        .en   (1'b1),
        .port (dclk_if)
    );

    wire        tog_d  = dclk_if.sync[0];
    wire        nrst_d = dclk_if.sync[1];
    logic [3:0] shcnt_reg;
    logic [3:0] shcnt_next;
    wire        new_word = (tog_d != ack_link_reg);
    assign shcnt_next = new_word ? tacl_pkg::SHIFT_FIRST :
                        (shcnt_reg == tacl_pkg::SHIFT_LAST) ? shcnt_reg :
                        shcnt_reg + 4'h1;

    always_ff @(posedge data_clk) begin
        if (!nrst_d) begin
            ack_link_reg  <= 1'b0;
            shcnt_reg     <= 4'h0;
            gray_link_reg <= 4'h0;
        end else begin
            if (new_word) begin
                ack_link_reg <= tog_d;
            end
            shcnt_reg     <= shcnt_next;
            gray_link_reg <= shcnt_next ^ (shcnt_next >> 1);
        end
    end
endmodule : tacl_core

//--- design/tacl_pkg.sv
// Purpose: Shared constants and types for the tracking converter counter and latch
// Assumes: System clock of 125 MHz
// Notes:   Far-side timing figures are kept here for reference; neither the bench nor the core reads them
package tacl_pkg;

    localparam int        RESULT_W      = 10;
    localparam int        SHIFT_W       = 4;
    localparam int        SYS_CLK_MHZ   = 125;
    localparam logic [9:0] COUNT_RESET  = 10'h000;
    localparam logic [9:0] COUNT_TOP    = 10'h3ff;
    localparam logic [9:0] COUNT_BOTTOM = 10'h000;
    localparam logic [3:0] SHIFT_LAST   = 4'ha;
    localparam logic [3:0] SHIFT_FIRST  = 4'h1;

    // Far-side timing, in ns, with cycle counts at the system clock
    localparam int CONV_CLK_MIN_PERIOD_NS = 1000;
    localparam int XFER_SETUP_MIN_NS      = 150;
    localparam int XFER_HIGH_MIN_NS       = 50;
    localparam int DCLK_PHASE_MIN_NS      = 100;
    localparam int XFER_SETUP_CYC = (XFER_SETUP_MIN_NS * SYS_CLK_MHZ + 999) / 1000;
    localparam int XFER_HIGH_CYC  = (XFER_HIGH_MIN_NS * SYS_CLK_MHZ + 999) / 1000;
    localparam int DCLK_PHASE_CYC = (DCLK_PHASE_MIN_NS * SYS_CLK_MHZ + 999) / 1000;

    typedef enum logic [1:0] {
        TACL_HOLD,
        TACL_UP,
        TACL_DOWN
    } tacl_dir_t;

endpackage : tacl_pkg

//--- design/tacl_sync.sv
// Purpose: Two flip-flop synchroniser for a group of independent levels
// Assumes: Each bit is a level; multi-bit words arrive gray coded
// Notes:   First stage is read only by the second
`timescale 1ns/1ps
module tacl_sync #(
    parameter int W = 1
) (
    input  wire logic clk,
    input  wire logic en,
    tacl_sync_if.dst  port
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] sync_reg;

    always_ff @(posedge clk) begin
        if (en) begin
            meta_reg <= port.raw;
            sync_reg <= meta_reg;
        end
    end

    assign port.sync = sync_reg;
endmodule : tacl_sync

//--- design/tacl_sync_if.sv
// Purpose: Carrier between a raw source and its two-stage synchroniser
// Assumes: Raw side may be asynchronous to the synchroniser clock
// Notes:   Width set per instance
`timescale 1ns/1ps
interface tacl_sync_if #(
    parameter int W = 1
);
    logic [W-1:0] raw;
    logic [W-1:0] sync;

    modport src (output raw, input sync);
    modport dst (input raw, output sync);
endinterface : tacl_sync_if

//--- verif/tacl_core_properties.sv
// Purpose: Port checks for the converter core
// Assumes: One clk domain; pins change just after clk edges
// Notes:   Bound to every tacl_core below
`timescale 1ns/1ps
module tacl_core_chk #(
    parameter int RESULT_W = 10
) (
    input wire logic                clk,
    input wire logic                nrst,
    input wire logic                conv_clk_pin,
    input wire logic                xfer_strobe_pin,
    input wire logic                send_data_pin,
    input wire logic                data_clk,
    input wire logic [RESULT_W-1:0] dac_code,
    input wire logic [RESULT_W-1:0] bit_out,
    input wire logic [RESULT_W-1:0] bit_oe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    a_one_step: assert property (dac_code == $past(dac_code)
        || dac_code == $past(dac_code) + 1'b1 || dac_code == $past(dac_code) - 1'b1)
        else $error("count moved by more than one code");
    a_no_wrap: assert property (($past(dac_code) == '1 |-> dac_code != '0) and
        ($past(dac_code) == '0 |-> dac_code != '1)) else $error("count wrapped");
    a_step_on_fall: assert property ($changed(dac_code) |-> !$past(conv_clk_pin, 3))
        else $error("count moved without a conversion clock fall");
    a_oe_follow: assert property (nrst [*4] |->
        bit_oe == {RESULT_W{$past(send_data_pin, 3)}}) else $error("enables lag send pin");
    a_oe_same: assert property (bit_oe == '0 || bit_oe == '1)
        else $error("enables disagree");
    a_oe_off: assert property (!send_data_pin [*4] |-> bit_oe == '0)
        else $error("outputs still driven");
    a_pass_thru: assert property ((xfer_strobe_pin && $stable(dac_code)) [*6] |->
        bit_out == dac_code) else $error("open latch does not show the count");
    // Eight quiet samples outlast the shift path from a data clock rise
    a_latch_hold: assert property ((!xfer_strobe_pin && $stable(data_clk)) [*8] |->
        $stable(bit_out)) else $error("held word moved");
    c_full_word: cover property (dac_code == 10'h201);
    c_latched: cover property ($fell(xfer_strobe_pin));
    c_off: cover property (bit_oe == '0);
endmodule : tacl_core_chk

bind tacl_core tacl_core_chk #(.RESULT_W(RESULT_W)) i_chk (.clk(clk), .nrst(nrst),
    .conv_clk_pin(conv_clk_pin), .xfer_strobe_pin(xfer_strobe_pin), .data_clk(data_clk),
    .send_data_pin(send_data_pin), .dac_code(dac_code), .bit_out(bit_out), .bit_oe(bit_oe));

//--- verif/tacl_core_tb_top.sv
// Purpose: Directed bench for the converter core
// Assumes: Conversion period of 125 clk cycles
// Notes:   Reset spans one reader frame for the data clock domain
`timescale 1ns/1ps
module tacl_core_tb_top;
    logic       clk = 1'b0, lclk = 1'b0, nrst = 1'b0, conv = 1'b0, below = 1'b0, ce = 1'b1;
    logic       above = 1'b0, strobe = 1'b1, send = 1'b1, start = 1'b0, data_clk, busy;
    logic [9:0] dac_code, bit_out, bit_oe, word;
    int         error_cnt = 0, n_checks = 0, cyc = 0;
    always #4 clk = ~clk;
    always begin
        #32.3 lclk = 1'b1;
        #31.7 lclk = 1'b0;
    end
    tacl_core i_dut (.clk(clk), .nrst(nrst), .ce(ce), .conv_clk_pin(conv),
        .dac_below_pin(below), .dac_above_pin(above), .xfer_strobe_pin(strobe),
        .send_data_pin(send), .data_clk(data_clk), .dac_code(dac_code), .bit_out(bit_out),
        .bit_oe(bit_oe));
    tacl_host i_host (.lclk(lclk), .start(start), .msb_in(bit_out[9]), .data_clk(data_clk),
        .word(word), .busy(busy));
    task automatic chk(input logic [9:0] seen, input logic [9:0] want, input string what);
        n_checks++;
        if (seen !== want) begin
            error_cnt++;
            $display("unexpected %s: expected %h, seen %h", what, want, seen);
        end
    endtask : chk
    task automatic give_verdict;
        $display("checks %0d, mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : give_verdict
    task automatic steps(input logic up, input logic dn, input int n, input logic [9:0] want);
        below <= up;
        above <= dn;
        repeat (n) begin
            repeat (4) @(posedge clk);
            conv <= 1'b1;
            repeat (12) @(posedge clk);
            conv <= 1'b0;
            repeat (109) @(posedge clk);
        end
        chk(dac_code, want, "count");
    endtask : steps
    task automatic frame;
        start <= 1'b1;
        while (busy !== 1'b1) @(posedge clk);
        start <= 1'b0;
        while (busy !== 1'b0) @(posedge clk);
    endtask : frame
    initial begin
        frame();
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        steps(1'b0, 1'b1, 2, 10'h000);
        for (int i = 1; i <= 513; i++) steps(1'b1, 1'b0, 1, 10'(i));
        chk(bit_out, 10'h201, "open latch");
        steps(1'b0, 1'b0, 2, 10'h201);
        steps(1'b1, 1'b1, 1, 10'h201);
        // Enable low freezes the count even though the comparator asks for a step
        ce <= 1'b0;
        steps(1'b1, 1'b0, 1, 10'h201);
        ce <= 1'b1;
        steps(1'b0, 1'b1, 2, 10'h1ff);
        steps(1'b1, 1'b0, 2, 10'h201);
        strobe <= 1'b0;
        steps(1'b1, 1'b0, 3, 10'h204);
        chk(bit_out, 10'h201, "held word");
        frame();
        chk(word, 10'h201, "serial word");
        strobe <= 1'b1;
        repeat (8) @(posedge clk);
        strobe <= 1'b0;
        send <= 1'b0;
        repeat (8) @(posedge clk);
        chk(bit_oe, 10'h000, "enables off");
        send <= 1'b1;
        repeat (8) @(posedge clk);
        chk(bit_out, 10'h204, "relatched word");
        give_verdict();
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            error_cnt++;
            give_verdict();
        end
    end
endmodule : tacl_core_tb_top

//--- verif/tacl_host.sv
// Purpose: Host reader that clocks the held word out serially
// Assumes: lclk of 64 ns; start held until busy
// Notes:   Data clock stands low between frames
`timescale 1ns/1ps
module tacl_host (
    input  wire logic lclk,
    input  wire logic start,
    input  wire logic msb_in,
    output logic      data_clk,
    output logic [9:0] word,
    output logic      busy
);
    logic [5:0] step_reg;
    // Eleven rises, 128 ns phases; last step is 0x2d
    wire        dclk_next = (step_reg[1:0] == 2'h1 || step_reg[1:0] == 2'h2) &&
                            step_reg != 6'h2d;
    initial busy = 1'b0;
    initial data_clk = 1'b0;
    always @(posedge lclk) begin
        if (start && !busy) begin
            busy <= 1'b1;
            step_reg <= 6'h00;
            word <= {msb_in, 9'h000};
        end else if (busy) begin
            step_reg <= step_reg + 6'h01;
            // Registered so the clock cannot glitch when busy and step change together
            data_clk <= dclk_next;
            // First two rises only carry the latch event across; the third gives shift one
            if (step_reg[1:0] == 2'h1 && step_reg[5:2] >= 4'h2) begin
                word[4'hb - step_reg[5:2]] <= msb_in;
            end
            if (step_reg == 6'h2d) begin
                busy <= 1'b0;
            end
        end
    end
endmodule : tacl_host
